// File: include/eeprom_defs.svh
/*
 Constants of the serial EEPROM command logic: opcodes, array geometry,
 lock range codes and engine timing. Assumes inclusion by bare name.
*/
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH
`define EE_OP_SET_LATCH   8'h06
`define EE_OP_CLR_LATCH   8'h04
`define EE_OP_WRITE       8'h02
`define EE_OP_READ        8'h03
`define EE_OP_STATUS      8'h05
`define EE_OP_LOCK        8'h01
`define EE_ADDR_W         9
`define EE_WORDS          512
`define EE_PAGE_BYTES     16
`define EE_LOCK_NONE      3'h0
`define EE_LOCK_Q1        3'h1
`define EE_LOCK_Q2        3'h2
`define EE_LOCK_Q3        3'h3
`define EE_LOCK_Q4        3'h4
`define EE_LOCK_HALF      3'h5
`define EE_LOCK_PAGE      3'h7
`define EE_LOCK_RESET     3'h0
`define EE_WRITE_CYCLES   4000
`define EE_DRAIN_SPACING  2'h3
`endif

// File: include/eeprom_pkg.sv
/*
 Types of the serial EEPROM command logic: frame states, write engine
 states and the FIFO entry carrier. Assumes eeprom_defs.svh on the path.
*/
`include "eeprom_defs.svh"
package eeprom_pkg;
   typedef enum logic [7:0] {
      FR_IDLE   = 8'h01,
      FR_OPC    = 8'h02,
      FR_ADDR   = 8'h04,
      FR_RDATA  = 8'h08,
      FR_WDATA  = 8'h10,
      FR_STAT   = 8'h20,
      FR_LOCK   = 8'h40,
      FR_IGNORE = 8'h80
   } frame_type;
   typedef enum logic [2:0] {
      EN_IDLE  = 3'h1,
      EN_LOAD  = 3'h2,
      EN_TIMER = 3'h4
   } engine_type;
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] data;
   } wr_entry_type;
endpackage : eeprom_pkg

// File: rtl/spi_eeprom_command_logic.sv
/*
 SPI slave command logic of a 512 x 8 EEPROM with a self-timed write engine
 and the array itself, plus the FIFO that carries committed bytes to it.
 Assumes SPI pins are asynchronous to mclk and much slower (sck >= 8 mclk).
*/
// Functional notes
// - Read: opcode, 16-bit address, low 9 used
// - Continued clocking reads next location automatically
// - Read address wraps from top to zero
// - Chip select high ends read, output released
// - Status byte: lock code low, upper zeros
// - Status read shows high while write busy
// - Status bit pointer advances while busy
// - Set latch only if select rises after it
// - Write: opcode, 16-bit address, then data
// - Up to sixteen bytes within one page
// - Page pointer wraps inside the page
// - Commit only on select rise at boundary
// - Opcodes 06/04 set and clear latch
// - Opcodes 02 write, 03 read, 05 status
// - Everything travels most significant bit first
// - Lock command: opcode 01 plus one byte
// - Select rise after lock byte starts write
// - Later lock byte replaces the earlier one
// - Codes one to four lock quarters
// - Code five lower half, seven lowest page
// - Power-up idle, released, latch cleared
// - Latch clears when data write completes
// - Locked bytes stay readable, never written
// - Sample on sck rise, drive on fall
// - Write protect low blocks nonvolatile writes
`timescale 1ns/1ps
`include "eeprom_defs.svh"

module wr_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_q,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("wr_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wptr_r;
   logic [AW:0]      rptr_r;
   assign in_ready  = (wptr_r - rptr_r) != (AW + 1)'(DEPTH);
   assign out_valid = wptr_r != rptr_r;
   assign out_data  = mem[rptr_r[AW-1:0]];
   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (in_valid && in_ready) wptr_r <= wptr_r + 1'b1;
         if (out_valid && out_ready) rptr_r <= rptr_r + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (in_valid && in_ready) mem[wptr_r[AW-1:0]] <= in_data;
   end
endmodule : wr_fifo

module spi_eeprom_command_logic
   import eeprom_pkg::*;
#(
   parameter int WRITE_CYCLES = `EE_WRITE_CYCLES,
   parameter int FIFO_DEPTH   = 4
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // SPI pins
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic       si,
   input  wire logic       wp_n,
   output logic            so,
   output logic            so_oe,
   // Status
   output logic            write_busy,
   output logic            write_latch,
   output logic [2:0]      lock_range_code
);
   if (WRITE_CYCLES < 8 || WRITE_CYCLES > 65535) begin : g_bad_cycles
      $error("WRITE_CYCLES out of range");
   end

   typedef struct packed {
      frame_type        fr;
      engine_type       en;
      logic [2:0]       bitcnt;
      logic             addr_hi_done;
      logic             is_rd;
      logic [7:0]       shift_in;
      logic [8:0]       addr;
      logic [7:0]       out_sh;
      logic             so;
      logic             so_oe;
      logic             wel;
      logic             wp_drop;
      logic [2:0]       lock_code;
      logic [2:0]       lock_buf;
      logic             lock_got;
      logic [4:0]       pg_base;
      logic [3:0]       pg_ptr;
      logic [15:0][7:0] pg_data;
      logic [15:0]      pg_valid;
      logic             do_status;
      logic [4:0]       load_idx;
      logic [15:0]      timer;
      logic [1:0]       drain_cnt;
      logic             busy;
   } ctl_type;

   function automatic logic is_locked(input logic [2:0] code, input logic [8:0] a);
      unique case (code)
         `EE_LOCK_Q1:   is_locked = a[8:7] == 2'h0;
         `EE_LOCK_Q2:   is_locked = a[8:7] == 2'h1;
         `EE_LOCK_Q3:   is_locked = a[8:7] == 2'h2;
         `EE_LOCK_Q4:   is_locked = a[8:7] == 2'h3;
         `EE_LOCK_HALF: is_locked = a[8] == 1'b0;
         `EE_LOCK_PAGE: is_locked = a[8:4] == 5'h00;
         default:       is_locked = 1'b0;
      endcase
   endfunction : is_locked

   // Reset release and pin synchronisers
   logic [1:0] rst_sync_r;
   logic       rst_q;
   logic [3:0] pin1_r;
   logic [3:0] pin2_r;
   logic [3:0] pin3_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rst_sync_r <= 2'h0;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_q = rst_sync_r[1];
   // Reset to low so a select held low through power-up is no falling edge
   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         pin1_r <= 4'h0;
         pin2_r <= 4'h0;
         pin3_r <= 4'h0;
      end else begin
         pin1_r <= {wp_n, si, sck, cs_n};
         pin2_r <= pin1_r;
         pin3_r <= pin2_r;
      end
   end
   logic cs_fall, cs_rise, sck_rise, sck_fall, si_s, wp_s, selected;
   assign cs_fall  = !pin2_r[0] && pin3_r[0];
   assign cs_rise  = pin2_r[0] && !pin3_r[0];
   assign sck_rise = pin2_r[1] && !pin3_r[1];
   assign sck_fall = !pin2_r[1] && pin3_r[1];
   assign si_s     = pin2_r[2];
   assign wp_s     = pin2_r[3];
   assign selected = !pin2_r[0];

   // Array and write FIFO
   logic [7:0]   mem [`EE_WORDS];
   wr_entry_type push_entry, pop_entry;
   logic         push_valid, push_ready, pop_valid, pop_ready;
   ctl_type      st_r, st_nxt;

   wr_fifo #(
      .WIDTH ($bits(wr_entry_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rst_q     (rst_q),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_entry),
      .out_valid (pop_valid),
      .out_ready (pop_ready),
      .out_data  (pop_entry)
   );
   // Array writes are paced slower than loads so the FIFO really backs up
   assign pop_ready = st_r.drain_cnt == 2'h0;
   always_ff @(posedge mclk) begin
      if (pop_valid && pop_ready) mem[pop_entry.addr] <= pop_entry.data;
   end

   always_comb begin
      logic [7:0] byte_in;
      logic       byte_done;
      logic [8:0] new_addr;
      logic [8:0] ld_addr;
      byte_in   = {st_r.shift_in[6:0], si_s};
      byte_done = st_r.bitcnt == 3'h7;
      new_addr  = {st_r.addr[8], byte_in};
      ld_addr   = {st_r.pg_base, st_r.load_idx[3:0]};
      st_nxt    = st_r;
      push_valid = 1'b0;
      push_entry = '{addr: ld_addr, data: st_r.pg_data[st_r.load_idx[3:0]]};
      st_nxt.drain_cnt = (st_r.drain_cnt == `EE_DRAIN_SPACING) ? 2'h0 : st_r.drain_cnt + 1'b1;
      if (selected && !wp_s) st_nxt.wp_drop = 1'b1;

      // Frame logic; select rise takes priority over a clock edge
      if (cs_rise) begin
         st_nxt.fr    = FR_IDLE;
         st_nxt.so_oe = 1'b0;
         if (st_r.fr == FR_OPC && st_r.bitcnt == 3'h0 && st_r.is_rd) st_nxt.wel = 1'b1;
         if (st_r.fr == FR_WDATA && st_r.bitcnt == 3'h0 && |st_r.pg_valid && st_r.wel
             && !st_nxt.wp_drop && !st_r.busy) begin
            st_nxt.en        = EN_LOAD;
            st_nxt.busy      = 1'b1;
            st_nxt.do_status = 1'b0;
            st_nxt.load_idx  = 5'h00;
         end
         if (st_r.fr == FR_LOCK && st_r.bitcnt == 3'h0 && st_r.lock_got && st_r.wel
             && !st_nxt.wp_drop && !st_r.busy) begin
            st_nxt.en        = EN_TIMER;
            st_nxt.busy      = 1'b1;
            st_nxt.do_status = 1'b1;
            st_nxt.timer     = 16'h0000;
         end
      end else if (cs_fall && st_r.fr == FR_IDLE) begin
         st_nxt.fr      = FR_OPC;
         st_nxt.bitcnt  = 3'h0;
         st_nxt.is_rd   = 1'b0;
         st_nxt.wp_drop = !wp_s;
      end else if (sck_rise && st_r.fr != FR_IDLE) begin
         st_nxt.shift_in = byte_in;
         st_nxt.bitcnt   = st_r.bitcnt + 1'b1;
         unique case (st_r.fr)
            FR_OPC: begin
               // A latch-set opcode waits here with is_rd marking it
               if (st_r.is_rd) begin
                  st_nxt.fr    = FR_IGNORE;
                  st_nxt.is_rd = 1'b0;
               end else if (byte_done) begin
                  st_nxt.addr_hi_done = 1'b0;
                  unique case (byte_in)
                     `EE_OP_SET_LATCH: st_nxt.is_rd = 1'b1;
                     `EE_OP_CLR_LATCH: begin
                        st_nxt.wel = 1'b0;
                        st_nxt.fr  = FR_IGNORE;
                     end
                     `EE_OP_READ: begin
                        st_nxt.fr    = st_r.busy ? FR_IGNORE : FR_ADDR;
                        st_nxt.is_rd = 1'b1;
                     end
                     `EE_OP_WRITE: st_nxt.fr = st_r.busy ? FR_IGNORE : FR_ADDR;
                     `EE_OP_STATUS: begin
                        st_nxt.fr     = FR_STAT;
                        st_nxt.out_sh = {5'h00, st_r.lock_code};
                        st_nxt.so_oe  = 1'b1;
                     end
                     `EE_OP_LOCK: begin
                        st_nxt.fr       = st_r.busy ? FR_IGNORE : FR_LOCK;
                        st_nxt.lock_got = 1'b0;
                     end
                     default: st_nxt.fr = FR_IGNORE;
                  endcase
               end
            end
            FR_ADDR: begin
               if (byte_done && !st_r.addr_hi_done) begin
                  st_nxt.addr         = {byte_in[0], 8'h00};
                  st_nxt.addr_hi_done = 1'b1;
               end else if (byte_done && st_r.is_rd) begin
                  st_nxt.fr     = FR_RDATA;
                  st_nxt.out_sh = mem[new_addr];
                  st_nxt.addr   = new_addr + 1'b1;
                  st_nxt.so_oe  = 1'b1;
               end else if (byte_done) begin
                  st_nxt.fr       = FR_WDATA;
                  st_nxt.addr     = new_addr;
                  st_nxt.pg_base  = new_addr[8:4];
                  st_nxt.pg_ptr   = new_addr[3:0];
                  st_nxt.pg_valid = 16'h0000;
               end
            end
            FR_RDATA: begin
               if (byte_done) begin
                  st_nxt.out_sh = mem[st_r.addr];
                  st_nxt.addr   = st_r.addr + 1'b1;
               end
            end
            FR_WDATA: begin
               if (byte_done) begin
                  st_nxt.pg_data[st_r.pg_ptr]  = byte_in;
                  st_nxt.pg_valid[st_r.pg_ptr] = 1'b1;
                  st_nxt.pg_ptr = st_r.pg_ptr + 1'b1;
               end
            end
            FR_STAT: begin
               if (byte_done) st_nxt.out_sh = {5'h00, st_r.lock_code};
            end
            FR_LOCK: begin
               if (byte_done) begin
                  st_nxt.lock_buf = byte_in[2:0];
                  st_nxt.lock_got = 1'b1;
               end
            end
            FR_IGNORE: st_nxt.fr = FR_IGNORE;
         endcase
      end else if (sck_fall && (st_r.fr == FR_RDATA || st_r.fr == FR_STAT)) begin
         // Busy shows high but the status pointer still moves
         st_nxt.so     = (st_r.fr == FR_STAT && st_r.busy) ? 1'b1 : st_r.out_sh[7];
         st_nxt.out_sh = {st_r.out_sh[6:0], 1'b0};
      end

      // Self-timed write engine
      unique case (st_r.en)
         EN_IDLE: st_nxt.timer = 16'h0000;
         EN_LOAD: begin
            if (st_r.load_idx[4]) begin
               st_nxt.en = EN_TIMER;
            end else if (!st_r.pg_valid[st_r.load_idx[3:0]] || is_locked(st_r.lock_code, ld_addr)) begin
               st_nxt.load_idx = st_r.load_idx + 1'b1;
            end else begin
               push_valid = 1'b1;
               if (push_ready) st_nxt.load_idx = st_r.load_idx + 1'b1;
            end
         end
         EN_TIMER: begin
            st_nxt.timer = st_r.timer + 1'b1;
            if (st_r.timer >= 16'(WRITE_CYCLES - 1) && !pop_valid) begin
               st_nxt.en   = EN_IDLE;
               st_nxt.busy = 1'b0;
               if (st_r.do_status) begin
                  st_nxt.lock_code = st_r.lock_buf;
               end else begin
                  st_nxt.wel = st_nxt.wel && !st_r.wel;         // A latch set in this cycle wins only if the latch was clear before
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         st_r           <= '0;
         st_r.fr        <= FR_IDLE;
         st_r.en        <= EN_IDLE;
         st_r.lock_code <= `EE_LOCK_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign so              = st_r.so;
   assign so_oe           = st_r.so_oe;
   assign write_busy      = st_r.busy;
   assign write_latch     = st_r.wel;
   assign lock_range_code = st_r.lock_code;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_q);
   a_select_release: assert property (cs_rise |=> st_r.fr == FR_IDLE && !st_r.so_oe)
      else $error("output not released after select rise");
   a_unknown_quiet: assert property (st_r.fr == FR_IGNORE |-> !st_r.so_oe)
      else $error("output driven in ignored frame");
   a_read_wrap: assert property (st_r.fr == FR_RDATA && sck_rise && st_r.bitcnt == 3'h7
         && st_r.addr == 9'h1ff && !cs_rise |=> st_r.addr == 9'h000)
      else $error("read address did not wrap");
   a_busy_high: assert property (st_r.fr == FR_STAT && st_r.busy && sck_fall && !cs_rise
         |=> st_r.so)
      else $error("busy status not high");
   a_status_zero: assert property (st_r.fr == FR_STAT && !st_r.busy && sck_fall && !cs_rise
         && st_r.bitcnt inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h4} |=> !st_r.so)
      else $error("reserved status bit not zero");
   a_latch_set: assert property ($rose(st_r.wel) |-> $past(cs_rise))
      else $error("latch set without select rise");
   a_wp_block: assert property (cs_rise && !wp_s && !st_r.busy |=> !st_r.busy)
      else $error("write started under write protect");
   a_latch_done: assert property ($fell(st_r.busy) && !$past(st_r.do_status) && !$past(cs_rise)
         |-> !st_r.wel)
      else $error("latch not cleared after write");
   // Checked at the array port, past the FIFO, not at the gate that skips
   a_lock_skip: assert property (pop_valid && pop_ready |-> !is_locked(st_r.lock_code, pop_entry.addr))
      else $error("locked byte queued for write");
   a_commit_edge: assert property ($rose(st_r.busy) |-> $past(cs_rise) && $past(st_r.bitcnt) == 3'h0)
      else $error("write started off a byte boundary");
   c_read_wrap: cover property (st_r.fr == FR_RDATA && st_r.addr == 9'h000);
   c_page_commit: cover property ($rose(st_r.busy) && !st_r.do_status);
   c_fifo_full: cover property (push_valid && !push_ready);
   c_busy_status: cover property (st_r.fr == FR_STAT && st_r.busy && sck_fall);
endmodule : spi_eeprom_command_logic

// File: sim/spi_host_model.sv
/*
 Behavioural SPI host in mode 0 that drives select, clock and data for the EEPROM command logic.
 Assumes a 4 ns mclk; all pins move just after a falling mclk edge.
*/
`timescale 1ns/1ps

module spi_host_model (
   // Clock
   input  wire logic mclk,
   // Device output
   input  wire logic so,
   input  wire logic so_oe,
   // Host pins
   output logic      cs_n,
   output logic      sck,
   output logic      si
);
   // Six mclk per half period gives the 48 ns link clock
   localparam int HALF = 6;
   logic so_seen;
   // A released output floats, so a sample of it never matches data
   assign so_seen = so_oe ? so : 1'hz;
   initial begin
      cs_n = 1'h1;
      sck  = 1'h0;
      si   = 1'h0;
   end
   task automatic pause(input int n);
      repeat (n) @(negedge mclk);
   endtask : pause
   task automatic select();
      pause(1);
      cs_n = 1'h0;
      pause(HALF);
   endtask : select
   // Select rises only after a whole bit, so the caller picks the bit count
   task automatic deselect();
      pause(HALF);
      cs_n = 1'h1;
      pause(2 * HALF);
   endtask : deselect
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
         si = tx[i];                // Most significant bit first
         pause(HALF);
         rx[i] = so_seen;           // Settled since the last fall, taken before the rise
         sck = 1'h1;
         pause(HALF);
         sck = 1'h0;
      end
   endtask : xfer
endmodule : spi_host_model

// File: sim/spi_eeprom_command_logic_tb.sv
/*
 Self-checking bench of the EEPROM command logic: frames through the host model, shadow array.
 Assumes the design files, the package and spi_host_model compiled before it.
*/
`timescale 1ns/1ps
`include "eeprom_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module spi_eeprom_command_logic_tb;
   import eeprom_pkg::*;
   logic       mclk, rst_n, wp_n, cs_n, sck, si, so, so_oe, write_busy, write_latch;
   logic [2:0] lock_range_code, exp_code;
   logic [7:0] rx;
   logic [7:0] exp_mem [512];
   bit         known   [512];
   int         mismatches, samples_checked, cycles;

   spi_host_model host_i (.mclk(mclk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
   spi_eeprom_command_logic #(.WRITE_CYCLES(400)) spi_eeprom_command_logic_i (
      .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so),
      .so_oe(so_oe), .write_busy(write_busy), .write_latch(write_latch),
      .lock_range_code(lock_range_code));

   initial mclk = 1'h0;
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic send(input logic [7:0] q[$]);
      host_i.select();
      foreach (q[i]) host_i.xfer(q[i], 8, rx);
      host_i.deselect();
   endtask : send
   task automatic wait_idle();
      int n;
      host_i.pause(8);
      for (n = 0; n < 3000 && write_busy !== 1'h0; n++) host_i.pause(1);
      `CHK(write_busy, 1'h0)
   endtask : wait_idle
   task automatic stat(input int n, input logic [7:0] first, input logic [7:0] last);
      host_i.select();
      host_i.xfer(`EE_OP_STATUS, 8, rx);
      for (int k = 0; k < n; k++) begin
         host_i.xfer(8'h00, 8, rx);
         if (k == 0) `CHK(rx, first)
         if (k == n - 1) `CHK(rx, last)
      end
      host_i.deselect();
   endtask : stat
   // Header address bits above the ninth go out as zero
   task automatic wr(input logic [8:0] a, input logic [7:0] d[$], input bit takes, input bit poll);
      logic [7:0] q[$];
      logic [3:0] p;
      send('{`EE_OP_SET_LATCH});
      `CHK(write_latch, 1'h1)
      q = '{`EE_OP_WRITE, {7'h00, a[8]}, a[7:0]};
      q = {q, d};
      send(q);
      foreach (d[i]) begin
         p = a[3:0] + 4'(i);                     // Pointer stays in its page
         if (takes) exp_mem[{a[8:4], p}] = d[i];
         known[{a[8:4], p}] = 1'b1;
      end
      if (poll) stat(5, 8'hff, {5'h00, exp_code});
      wait_idle();
      if (takes) `CHK(write_latch, 1'h0)
   endtask : wr
   task automatic rd(input logic [8:0] a, input int n);
      logic [8:0] ad;
      host_i.select();
      host_i.xfer(`EE_OP_READ, 8, rx);
      host_i.xfer({7'h00, a[8]}, 8, rx);
      host_i.xfer(a[7:0], 8, rx);
      for (int k = 0; k < n; k++) begin
         ad = a + 9'(k);                         // Wraps from top to zero
         host_i.xfer(8'h00, 8, rx);
         if (known[ad]) `CHK(rx, exp_mem[ad])
      end
      host_i.deselect();
      `CHK(so_oe, 1'h0)
   endtask : rd
   task automatic refused(input logic [7:0] q[$], input int bits);
      host_i.select();
      foreach (q[i]) host_i.xfer(q[i], (i == q.size() - 1) ? bits : 8, rx);
      host_i.deselect();
      host_i.pause(20);
      `CHK(write_busy, 1'h0)
   endtask : refused

   logic [2:0] codes  [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h0};
   logic [8:0] locked [7] = '{9'h07f, 9'h080, 9'h100, 9'h1ff, 9'h0ff, 9'h00f, 9'h00f};
   logic [8:0] free   [7] = '{9'h080, 9'h07f, 9'h0ff, 9'h17f, 9'h100, 9'h010, 9'h1ff};

   initial begin
      rst_n = 1'h0;
      wp_n = 1'h1;
      exp_code = 3'h0;
      repeat (12) @(negedge mclk);
      rst_n = 1'h1;
      host_i.pause(8);
      `CHK(so_oe, 1'h0)
      `CHK(write_latch, 1'h0)
      `CHK(lock_range_code, 3'h0)
      stat(1, 8'h00, 8'h00);
      host_i.select();
      host_i.xfer(8'haa, 8, rx);
      host_i.xfer(8'h00, 8, rx);
      `CHK(rx, 8'hzz)
      host_i.deselect();
      $display("test reset and status done");
      send('{`EE_OP_SET_LATCH});
      `CHK(write_latch, 1'h1)
      send('{`EE_OP_CLR_LATCH});
      `CHK(write_latch, 1'h0)
      refused('{`EE_OP_SET_LATCH, `EE_OP_WRITE, 8'h00, 8'h10, 8'h55}, 8);
      `CHK(write_latch, 1'h0)
      $display("test latch done");
      wr(9'h000, '{8'h11, 8'h22}, 1, 0);
      wr(9'h1fc, '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5}, 1, 1);
      rd(9'h1fe, 4);
      rd(9'h1f0, 2);
      $display("test write and read done");
      wr(9'h020, '{8'h3c}, 1, 0);
      send('{`EE_OP_SET_LATCH});
      // One whole data byte first, so only the cut second byte can refuse the commit
      refused('{`EE_OP_WRITE, 8'h00, 8'h20, 8'h99, 8'h96}, 4);
      wp_n = 1'h0;
      send('{`EE_OP_SET_LATCH});
      refused('{`EE_OP_WRITE, 8'h00, 8'h20, 8'h98}, 8);
      rd(9'h000, 1);
      wp_n = 1'h1;
      send('{`EE_OP_CLR_LATCH});
      refused('{`EE_OP_WRITE, 8'h00, 8'h20, 8'h97}, 8);
      rd(9'h020, 1);
      $display("test refusals done");
      for (int r = 0; r < 7; r++) begin
         wr(locked[r], '{locked[r][7:0] ^ 8'h5a}, 1, 0);
         wr(free[r], '{free[r][7:0] ^ 8'h5a}, 1, 0);
      end
      for (int r = 0; r < 7; r++) begin
         send('{`EE_OP_SET_LATCH});
         send('{`EE_OP_LOCK, 8'h06, {5'h00, codes[r]}});
         exp_code = codes[r];
         wait_idle();
         `CHK(lock_range_code, codes[r])
         stat(1, {5'h00, codes[r]}, {5'h00, codes[r]});
         wr(locked[r], '{8'hc0 + 8'(r)}, codes[r] == 3'h0, 0);
         wr(free[r], '{8'he0 + 8'(r)}, 1, 0);
         rd(locked[r], 1);
         rd(free[r], 1);
      end
      $display("test lock ranges done");
      close_out();
   end
endmodule : spi_eeprom_command_logic_tb
